// >>> design/psoe_regs.svh
`ifndef PSOE_REGS_SVH
`define PSOE_REGS_SVH
// ==========================================
// port map
`define PSOE_PORT_CTRL 3'h6
`define PSOE_CTRL_RST 8'h00
`define PSOE_STAT_RST 8'hFF
`define PSOE_SELF_BIT 6
`endif

// >>> design/psoe_pkg.sv
`default_nettype none
package psoe_pkg;
  // ==========================================
  // state
  typedef struct packed {
    logic [7:0] ctrl;
    logic [7:0] stat;
    logic [7:0] rdata;
    logic rvalid;
    logic [7:0] oe_n;
    logic [7:0] strobe_s1;
    logic [7:0] strobe_s2;
    logic [7:0] ext_s1;
    logic [7:0] ext_s2;
  } psoe_state_t;
endpackage : psoe_pkg
`default_nettype wire

// >>> design/psoe_top.sv
// Behaviour
// - status read gives bit n =1 empty, 0 full for input port n
// - ports decode at base plus port number; control/status at base+6
// - control bits drive output enables of the other output ports
// - bit 0 =0 floats port 0 unless external enable low; =1 drives
// - bits 1-5 and 7 govern like-numbered ports
// - bit 6 gates no port; port 6 free of software control
// - port enabled when control bit 1 or external enable low
// - control keeps working even while port 6 drivers float
// - polling and software enable separately removable at build time
// - both removed: port 6 is standard, enables from external lines only
// - strobe high clears flag to full; CPU read of port sets empty
// - reset clears control and forces all enables high, floating ports 0-7
`include "psoe_regs.svh"
`default_nettype none
module psoe_top #(
  parameter bit POLL_EN = 1'b1,
  parameter bit SWOE_EN = 1'b1,
  parameter logic [7:0] BASE_ADDR = 8'h00
) (
  // clock and reset
  input wire logic SYS_CLK_I,
  input wire logic RESET_N_I,
  // cpu i/o bus
  input wire logic [7:0] ADDR_I,
  input wire logic IO_RD_I,
  input wire logic IO_WR_I,
  input wire logic [7:0] WDATA_I,
  output logic [7:0] RDATA_O,
  output logic RVALID_O,
  // port handshake pins
  input wire logic [7:0] LATCH_STROBE_I,
  input wire logic [7:0] EXT_OE_N_I,
  // output enables, low while driving
  output logic [7:0] PORT_OE_N_O,
  // self port data from control register
  output logic [7:0] CTRL_O
);
  // ==========================================
  // state
  psoe_pkg::psoe_state_t s_reg;
  psoe_pkg::psoe_state_t s_next;
  logic [7:0] offs;
  logic hit;
  logic [2:0] pnum;

  always_comb
  begin
    s_next = s_reg;
    offs = ADDR_I - BASE_ADDR;
    hit = (offs[7:3] == 5'h00);
    pnum = offs[2:0];
    s_next.strobe_s1 = LATCH_STROBE_I;
    s_next.strobe_s2 = s_reg.strobe_s1;
    s_next.ext_s1 = EXT_OE_N_I;
    s_next.ext_s2 = s_reg.ext_s1;
    s_next.rvalid = 1'b0;
    // ==========================================
    // register access
    if (hit && IO_WR_I && pnum == `PSOE_PORT_CTRL && SWOE_EN)
    begin
      s_next.ctrl = WDATA_I;
    end
    if (hit && IO_RD_I)
    begin
      s_next.rvalid = 1'b1;
      if (pnum == `PSOE_PORT_CTRL && POLL_EN)
      begin
        s_next.rdata = s_reg.stat;
      end
      else
      begin
        s_next.rdata = 8'h00;
      end
    end
    // ==========================================
    // status flags; strobe wins over read
    for (int i = 0; i < 8; i++)
    begin
      if (hit && IO_RD_I && pnum == i[2:0])
      begin
        s_next.stat[i] = 1'b1;
      end
      if (s_reg.strobe_s2[i])
      begin
        s_next.stat[i] = 1'b0;
      end
    end
    if (!POLL_EN)
    begin
      s_next.stat = `PSOE_STAT_RST;
    end
    // ==========================================
    // output enables
    for (int i = 0; i < 8; i++)
    begin
      if (i == `PSOE_SELF_BIT || !SWOE_EN)
      begin
        s_next.oe_n[i] = s_reg.ext_s2[i];
      end
      else
      begin
        s_next.oe_n[i] = ~(s_next.ctrl[i] | ~s_reg.ext_s2[i]);
      end
    end
    if (!RESET_N_I)
    begin
      s_next = '0;
      s_next.ctrl = `PSOE_CTRL_RST;
      s_next.stat = `PSOE_STAT_RST;
      s_next.oe_n = 8'hFF;
      s_next.ext_s1 = 8'hFF;
      s_next.ext_s2 = 8'hFF;
    end
  end

  always_ff @(posedge SYS_CLK_I)
  begin
    s_reg <= s_next;
  end

  assign RDATA_O = s_reg.rdata;
  assign RVALID_O = s_reg.rvalid;
  assign PORT_OE_N_O = s_reg.oe_n;
  assign CTRL_O = s_reg.ctrl;
endmodule : psoe_top
`default_nettype wire

// >>> bench/psoe_cpu.sv
`default_nettype none
module psoe_cpu (
  input wire logic clk,
  output logic [7:0] addr,
  output logic rd,
  output logic wr,
  output logic [7:0] wdata
);
  timeunit 1ns;
  timeprecision 1ps;
  initial {addr, rd, wr, wdata} = '0;
  // one bus cycle, held for one clock then released
  task automatic io(input logic r, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    {addr, wdata, rd, wr} <= {a, d, r, !r};
    @(posedge clk);
    {addr, rd, wr} <= {~a, 2'b00};
  endtask : io
endmodule : psoe_cpu
`default_nettype wire

// >>> bench/psoe_top_assertions.sv
`default_nettype none
module psoe_chk (
  input wire logic SYS_CLK_I, RESET_N_I, IO_RD_I, IO_WR_I, RVALID_O,
  input wire logic [7:0] ADDR_I, WDATA_I, RDATA_O, LATCH_STROBE_I,
  input wire logic [7:0] EXT_OE_N_I, PORT_OE_N_O, CTRL_O
);
  default clocking @(posedge SYS_CLK_I); endclocking
  default disable iff (!RESET_N_I);
  a_rst_ctrl: assert property (disable iff (1'b0) !RESET_N_I |=> CTRL_O == 8'h00)
    else $error("ctrl");
  a_rst_oe: assert property (disable iff (1'b0) !RESET_N_I |=> &PORT_OE_N_O)
    else $error("oe");
  a_wr_store: assert property (IO_WR_I && ADDR_I == 8'h06 |=> CTRL_O == $past(WDATA_I))
    else $error("store");
  a_rd_valid: assert property (IO_RD_I && ADDR_I < 8'h08 |=> RVALID_O) else $error("rv");
  a_no_read: assert property (!IO_RD_I |=> !RVALID_O) else $error("rv idle");
  a_oe_self: assert property ($stable(EXT_OE_N_I) [*4] |-> PORT_OE_N_O[6] == EXT_OE_N_I[6])
    else $error("oe6");
  a_oe_gate: assert property ($stable({EXT_OE_N_I, CTRL_O}) [*4] |->
    (PORT_OE_N_O | 8'h40) == (EXT_OE_N_I & ~CTRL_O | 8'h40)) else $error("gate");
  a_stat_full: assert property ($stable(LATCH_STROBE_I) [*4] ##0 (LATCH_STROBE_I[0] &&
    IO_RD_I && ADDR_I == 8'h06) |=> !RDATA_O[0]) else $error("full");
endmodule : psoe_chk
bind psoe_top psoe_chk chk (.*);
`default_nettype wire

// >>> bench/testbench.sv
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, rst_n = 0, rd, wr, rv;
  logic [7:0] ext = 8'hFF, stb = 8'h00, a, wd, rdat, oe, ctl;
  int errors = 0, checks_done = 0;
  // control, external enables, expected enables
  logic [7:0] rows [4][3] = '{'{8'h8D, 8'hFF, 8'h72}, '{8'h00, 8'h3E, 8'h3E},
    '{8'hFF, 8'hFF, 8'h40}, '{8'h40, 8'hBF, 8'hBF}};
  initial forever #2 clk = ~clk;
  psoe_cpu cpu (.clk(clk), .addr(a), .rd(rd), .wr(wr), .wdata(wd));
  psoe_top uut (.SYS_CLK_I(clk), .RESET_N_I(rst_n), .ADDR_I(a), .IO_RD_I(rd), .IO_WR_I(wr),
    .WDATA_I(wd), .RDATA_O(rdat), .RVALID_O(rv), .LATCH_STROBE_I(stb), .EXT_OE_N_I(ext),
    .PORT_OE_N_O(oe), .CTRL_O(ctl));
  task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
    checks_done++;
    if (s !== e)
    begin
      errors++;
      $display("[ERR] %s exp %h got %h", n, e, s);
    end
  endtask : chk
  task automatic print_verdict();
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : print_verdict
  initial
  begin
    repeat (12) @(posedge clk);
    rst_n <= 1;
    #1 chk("oe", oe, 8'hFF);
    chk("ctl", ctl, 8'h00);
    foreach (rows[i])
    begin
      cpu.io(0, 8'h06, rows[i][0]);
      ext <= rows[i][1];
      repeat (4) @(posedge clk);
      #1 chk("oe", oe, rows[i][2]);
    end
    // strobe, poll, read port 0, poll again
    @(posedge clk);
    stb <= 8'h01;
    repeat (4) @(posedge clk);
    stb <= 8'h00;
    repeat (4) @(posedge clk);
    cpu.io(1, 8'h06, 8'h00);
    #1 chk("stat", rdat, 8'hFE);
    chk("rv", {7'h00, rv}, 8'h01);
    cpu.io(1, 8'h00, 8'h00);
    #1 chk("rd0", rdat, 8'h00);
    cpu.io(1, 8'h06, 8'h00);
    #1 chk("stat", rdat, 8'hFF);
    cpu.io(0, 8'h16, 8'hFF);
    #1 chk("ctl", ctl, 8'h40);
    print_verdict();
  end
  initial
  begin
    #5000 errors++;
    print_verdict();
  end
endmodule : testbench
`default_nettype wire
